// File: shared/mcheck_pkg.sv
package mcheck_pkg;
  localparam int CODE_W = 64;
  // machine check code bit numbers (bit 0 is the most significant)
  localparam int B_SYSDMG = 0;
  localparam int B_INSNDMG = 1;
  localparam int B_TIMERDMG = 3;
  localparam int B_TIMINGDMG = 4;
  localparam int B_WARN = 8;
  localparam int B_DELAYED = 15;
  localparam int B_V_FLAGS = 20;
  localparam int B_V_MASKS = 21;
  localparam int B_V_PMCC = 22;
  localparam int B_V_IADDR = 23;
  localparam int B_V_FPR = 27;
  localparam int B_V_GPR = 28;
  localparam int B_V_CR = 29;
  localparam int B_V_STOR = 31;
  localparam int B_V_CPUTMR = 46;
  localparam int B_V_CLKCMP = 47;
  // fixed logout area layout, in bytes
  localparam logic [8:0] LOG_FIRST = 9'h000;
  localparam logic [8:0] LOG_LAST = 9'h1FF;
  localparam logic [8:0] SAVE_FIRST = 9'h0D8;
  localparam logic [8:0] CODE_ADDR = 9'h0E8;
  localparam logic [8:0] CODE_LAST = 9'h0EF;
  // status word and control register 14 bit positions
  localparam int PSW_MCHK_BIT = 13;
  localparam int CR14_STOP_BIT = 0;
  localparam int CR14_WARN_BIT = 4;
  localparam int CR14_EXT_BIT = 5;
  localparam logic RESET_EXT_MASK = 1'b1;
  localparam logic RESET_WARN_MASK = 1'b0;
  // software register map, word offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_CODE_HI = 4'h2;
  localparam logic [3:0] REG_CODE_LO = 4'h3;
  localparam logic [3:0] REG_VALID = 4'h4;
  // control register field positions
  localparam int CTRL_PSW13 = 0;
  localparam int CTRL_WARN = 1;
  localparam int CTRL_EXT = 2;
  localparam int CTRL_DONE = 3;
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_LOGOUT = 2'b01,
    ST_WAIT = 2'b10,
    ST_CHKSTOP = 2'b11
  } mc_state_e;
endpackage

// File: rtl/sticky_flag.sv
`timescale 1ns/1ns
module sticky_flag
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic setPulse,
  input wire logic clrPulse,
  output logic flag
);
  // set wins over clear
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      flag <= 1'b0;
    else if (setPulse)
      flag <= 1'b1;
    else if (clrPulse)
      flag <= 1'b0;
  end
endmodule // sticky_flag

// File: rtl/machine_check_interrupt_logic.sv
`timescale 1ns/1ns
// Behaviour
// - each malfunction falls into one of four types, masked in three groups
// - repressible conditions interrupt for logging, then operation resumes
// - uncorrectable errors in the current instruction are exigent
// - an interruption taken writes logout area bytes 0 to 511, stopping early on check-stop
// - logout area is 512 bytes with no processor-dependent data
// - eight-byte code at 232-239 gives type and field validity
// - save area from location 216 on is written as zeros apart from the code bytes
// - code bit 0 system, 1 instruction, 3 and 4 timing, 8 warning
// - code bit 15 marks a repressible condition held pending while disabled as an instruction retired
// - code bits 20 to 23 mark validity of old status word fields
// - bits 27-29, 31, 46, 47 mark save validity; 24-26, 30 unused
// - status bit 13 zero disables all machine check interruptions
// - warning and external masks gate warning and timer/timing damage under bit 13
// - fatal malfunctions enter check-stop at once
// - corrected single-bit storage errors raise no interruption
// - timing damage interrupts only with bit 13 and external mask set
// - system or instruction damage with bit 13 zero check-stops instead of interrupting
// - reset leaves external damage enabled, warning disabled
module machine_check_interrupt_logic
  import mcheck_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic sysDamageEvt,
  input wire logic insnDamageEvt,
  input wire logic timerDamageEvt,
  input wire logic timingDamageEvt,
  input wire logic warnEvt,
  input wire logic fatalEvt,
  input wire logic eccCorrectedEvt,
  input wire logic instrRetired,
  input wire logic [3:0] validIn,
  input wire logic [7:0] saveValidIn,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  output logic logWrEn,
  output logic [8:0] logAddr,
  output logic [7:0] logData,
  output logic mchkTaken,
  output logic checkStop
);
  mc_state_e state_r;
  mc_state_e state_nxt;
  logic psw13_r;
  logic warnMask_r;
  logic extMask_r;
  logic stopCtl_r;
  logic delayed_r;
  logic [CODE_W-1:0] code_r;
  logic [8:0] ptr_r;
  logic [31:0] rdata_r;
  logic logWrEn_r;
  logic [8:0] logAddr_r;
  logic [7:0] logData_r;
  logic taken_r;
  logic stop_r;
  logic sysPend;
  logic insnPend;
  logic timerPend;
  logic timingPend;
  logic warnPend;

  // ---- classification into the four types; pending flags
  wire inRun = (state_r == ST_RUN);
  wire exigentEvt = sysDamageEvt | insnDamageEvt;
  wire sysEn = psw13_r;
  wire timEn = psw13_r & extMask_r;
  wire warnEn = psw13_r & warnMask_r;
  wire timAny = timerPend | timingPend;
  wire takeNow = inRun & ((sysEn & (sysPend | insnPend)) |
                 (timEn & timAny) | (warnEn & warnPend));
  wire clrTaken = (state_r == ST_LOGOUT) && (ptr_r == 9'h000);
  // eccCorrectedEvt is deliberately unused: no flag, no interruption
  wire eccIgnored = eccCorrectedEvt;

  // pending flags persist while masked and clear when reported
  sticky_flag uSys (.core_clk(core_clk), .reset_n(reset_n),
    .setPulse(sysDamageEvt), .clrPulse(clrTaken & sysEn), .flag(sysPend));
  sticky_flag uInsn (.core_clk(core_clk), .reset_n(reset_n),
    .setPulse(insnDamageEvt), .clrPulse(clrTaken & sysEn), .flag(insnPend));
  sticky_flag uTmr (.core_clk(core_clk), .reset_n(reset_n),
    .setPulse(timerDamageEvt), .clrPulse(clrTaken & timEn),
    .flag(timerPend));
  sticky_flag uTfac (.core_clk(core_clk), .reset_n(reset_n),
    .setPulse(timingDamageEvt), .clrPulse(clrTaken & timEn),
    .flag(timingPend));
  sticky_flag uWarn (.core_clk(core_clk), .reset_n(reset_n),
    .setPulse(warnEvt), .clrPulse(clrTaken & warnEn), .flag(warnPend));

  // ---- check-stop decision
  wire exigentDisabled = exigentEvt & ~psw13_r;
  wire nestedDamage = exigentEvt & (state_r == ST_LOGOUT);
  wire goStop = fatalEvt | exigentDisabled | nestedDamage;

  // ---- delayed tracking: repressible pending while disabled, then executed
  wire repHeld = (timAny & ~timEn) | (warnPend & ~warnEn);
  wire delaySet = repHeld & instrRetired;

  // ---- machine check code image, bit 0 is the msb
  function automatic logic [CODE_W-1:0] put(input logic [CODE_W-1:0] c,
                                            input int bitNo,
                                            input logic v);
    logic [CODE_W-1:0] r;
    r = c;
    r[CODE_W-1-bitNo] = v;
    return r;
  endfunction

  logic [CODE_W-1:0] codeBuild;
  always_comb
  begin
    codeBuild = '0; // unused bits stay zero
    codeBuild = put(codeBuild, B_SYSDMG, sysEn & sysPend);
    codeBuild = put(codeBuild, B_INSNDMG, sysEn & insnPend);
    codeBuild = put(codeBuild, B_TIMERDMG, timEn & timAny);
    codeBuild = put(codeBuild, B_TIMINGDMG, timEn & timAny);
    codeBuild = put(codeBuild, B_WARN, warnEn & warnPend);
    codeBuild = put(codeBuild, B_DELAYED, delayed_r | delaySet);
    codeBuild = put(codeBuild, B_V_FLAGS, validIn[0]);
    codeBuild = put(codeBuild, B_V_MASKS, validIn[1]);
    codeBuild = put(codeBuild, B_V_PMCC, validIn[2]);
    codeBuild = put(codeBuild, B_V_IADDR, validIn[3]);
    codeBuild = put(codeBuild, B_V_FPR, saveValidIn[0]);
    codeBuild = put(codeBuild, B_V_GPR, saveValidIn[1]);
    codeBuild = put(codeBuild, B_V_CR, saveValidIn[2]);
    codeBuild = put(codeBuild, B_V_STOR, saveValidIn[3]);
    codeBuild = put(codeBuild, B_V_CPUTMR, saveValidIn[4]);
    codeBuild = put(codeBuild, B_V_CLKCMP, saveValidIn[5]);
  end

  // ---- logout byte stream: code bytes at 232..239, save area flagged
  wire [2:0] codeIdx = 3'(ptr_r - CODE_ADDR);
  wire inCode = (ptr_r >= CODE_ADDR) && (ptr_r <= CODE_LAST);
  wire [7:0] codeByte = code_r[CODE_W-1-8*int'(codeIdx) -: 8];
  // non-code bytes carry only architected content; zero filler
  wire [7:0] byteOut = inCode ? codeByte : 8'h00;
  wire inSave = (ptr_r >= SAVE_FIRST);
  wire lastByte = (ptr_r == LOG_LAST);

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN:
        if (goStop)
          state_nxt = ST_CHKSTOP;
        else if (takeNow)
          state_nxt = ST_LOGOUT;
      ST_LOGOUT:
        if (goStop)
          state_nxt = ST_CHKSTOP;
        else if (lastByte)
          state_nxt = ST_WAIT;
      ST_WAIT:
        if (goStop)
          state_nxt = ST_CHKSTOP;
        else if (regWr && regAddr == REG_CTRL && regWdata[CTRL_DONE])
          state_nxt = ST_RUN;
      ST_CHKSTOP:
        state_nxt = ST_CHKSTOP; // only reset leaves
      default:
        state_nxt = ST_CHKSTOP;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      state_r <= ST_RUN;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      ptr_r <= LOG_FIRST;
    else if (state_r == ST_LOGOUT && !lastByte)
      ptr_r <= ptr_r + 9'h001;
    else if (state_r != ST_LOGOUT)
      ptr_r <= LOG_FIRST;
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      code_r <= '0;
    else if (takeNow && !goStop)
      code_r <= codeBuild;
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      delayed_r <= 1'b0;
    else if (takeNow && !goStop)
      delayed_r <= 1'b0;
    else if (delaySet)
      delayed_r <= 1'b1;
  end

  // ---- control register writes; reset masks per architected reset state
  wire ctrlWr = regWr && (regAddr == REG_CTRL);
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      psw13_r <= 1'b0;
      warnMask_r <= RESET_WARN_MASK;
      extMask_r <= RESET_EXT_MASK;
      stopCtl_r <= 1'b1;
    end
    else if (ctrlWr)
    begin
      psw13_r <= regWdata[CTRL_PSW13];
      warnMask_r <= regWdata[CTRL_WARN];
      extMask_r <= regWdata[CTRL_EXT];
    end
  end

  // ---- register reads, data one cycle later
  wire [31:0] ctrlRd = {28'h0, 1'b0, extMask_r, warnMask_r, psw13_r};
  wire [31:0] statRd = {22'h0, eccIgnored & 1'b0, stopCtl_r, state_r,
                        delayed_r, warnPend, timingPend, timerPend,
                        insnPend, sysPend};
  wire [31:0] validRd = {20'h0, saveValidIn, validIn};
  wire [31:0] rdMux =
    (regAddr == REG_CTRL) ? ctrlRd :
    (regAddr == REG_STATUS) ? statRd :
    (regAddr == REG_CODE_HI) ? code_r[63:32] :
    (regAddr == REG_CODE_LO) ? code_r[31:0] :
    (regAddr == REG_VALID) ? validRd : 32'h0000_0000;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      rdata_r <= 32'h0000_0000;
    else if (regRd)
      rdata_r <= rdMux;
    else
      rdata_r <= 32'h0000_0000;
  end

  // ---- registered outputs
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      logWrEn_r <= 1'b0;
      logAddr_r <= LOG_FIRST;
      logData_r <= 8'h00;
      taken_r <= 1'b0;
      stop_r <= 1'b0;
    end
    else
    begin
      logWrEn_r <= (state_r == ST_LOGOUT) && !goStop;
      logAddr_r <= ptr_r;
      logData_r <= inSave ? byteOut : 8'h00;
      taken_r <= takeNow && !goStop;
      stop_r <= (state_nxt == ST_CHKSTOP);
    end
  end

  assign regRdata = rdata_r;
  assign logWrEn = logWrEn_r;
  assign logAddr = logAddr_r;
  assign logData = logData_r;
  assign mchkTaken = taken_r;
  assign checkStop = stop_r;
endmodule // machine_check_interrupt_logic

// File: bench/mcheck_properties.sv
`timescale 1ns/1ns
module mcheck_properties
  import mcheck_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic fatalEvt,
  input wire logic logWrEn,
  input wire logic [8:0] logAddr,
  input wire logic [7:0] logData,
  input wire logic mchkTaken,
  input wire logic checkStop
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  property p_take_log;
    mchkTaken |=> logWrEn && logAddr == LOG_FIRST;
  endproperty
  a_take_log: assert property (p_take_log)
    else $error("logout did not start after interruption");
  property p_addr_step;
    logWrEn && logAddr != LOG_LAST |=>
      checkStop || (logWrEn && logAddr == $past(logAddr) + 9'h001);
  endproperty
  a_addr_step: assert property (p_addr_step)
    else $error("logout bytes not consecutive");
  property p_log_end;
    logWrEn && logAddr == LOG_LAST |=> !logWrEn;
  endproperty
  a_log_end: assert property (p_log_end)
    else $error("logout ran past last byte");
  property p_stop_hold;
    checkStop |=> checkStop;
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("check-stop left without reset");
  property p_stop_quiet;
    checkStop |-> !mchkTaken;
  endproperty
  a_stop_quiet: assert property (p_stop_quiet)
    else $error("interruption taken in check-stop");
  property p_fatal_stop;
    fatalEvt |=> checkStop;
  endproperty
  a_fatal_stop: assert property (p_fatal_stop)
    else $error("fatal event did not stop");
  property p_busy;
    logWrEn |-> !mchkTaken;
  endproperty
  a_busy: assert property (p_busy)
    else $error("second interruption during logout");
  property p_zero;
    logWrEn && (logAddr < CODE_ADDR || logAddr > CODE_LAST) |->
      logData == 8'h00;
  endproperty
  a_zero: assert property (p_zero)
    else $error("nonzero byte outside code");
  property p_unused;
    logWrEn && logAddr == 9'h0EB |-> logData[7:5] == 3'h0 && !logData[1];
  endproperty
  a_unused: assert property (p_unused)
    else $error("unused code bits set");
  c_take: cover property (mchkTaken);
  c_stop: cover property ($rose(checkStop));
  c_end: cover property (logWrEn && logAddr == LOG_LAST);
endmodule // mcheck_properties

bind machine_check_interrupt_logic mcheck_properties mcp (
  .core_clk(core_clk), .reset_n(reset_n), .fatalEvt(fatalEvt),
  .logWrEn(logWrEn), .logAddr(logAddr), .logData(logData),
  .mchkTaken(mchkTaken), .checkStop(checkStop));

// File: bench/tb_top.sv
`timescale 1ns/1ns
module tb_top
  import mcheck_pkg::*;
;
  // validity bits 20-23, 27-29, 31, 46, 47 with all inputs valid
  localparam logic [63:0] VAL = 64'h0000_0F1D_0003_0000;
  logic core_clk = 1'b0, reset_n = 1'b0, regWr = 1'b0, regRd = 1'b0;
  logic [7:0] ev = 8'h00, logData;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0, regRdata;
  logic logWrEn, mchkTaken, checkStop;
  logic [8:0] logAddr;
  logic [7:0] mem [0:511];
  int error_cnt = 0, num_checks = 0, logCnt = 0, takeCnt = 0;
  int logBase = 0, takeBase = 0;
  logic [3:0] vIn = 4'hF;
  logic [7:0] svIn = 8'h3F;
  always #4 core_clk = ~core_clk;
  machine_check_interrupt_logic uut (.core_clk(core_clk),
    .reset_n(reset_n), .sysDamageEvt(ev[0]), .insnDamageEvt(ev[1]),
    .timerDamageEvt(ev[2]), .timingDamageEvt(ev[3]), .warnEvt(ev[4]),
    .fatalEvt(ev[5]), .eccCorrectedEvt(ev[6]), .instrRetired(ev[7]),
    .validIn(vIn), .saveValidIn(svIn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .logWrEn(logWrEn), .logAddr(logAddr),
    .logData(logData), .mchkTaken(mchkTaken), .checkStop(checkStop));
  always @(posedge core_clk)
  begin
    if (logWrEn === 1'b1)
    begin
      mem[logAddr] <= logData;
      logCnt <= logCnt + 1;
    end
    if (mchkTaken === 1'b1)
      takeCnt <= takeCnt + 1;
  end
  task summarize;
    if (error_cnt == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    @(negedge core_clk);
    chk({32'h0, regRdata}, {32'h0, exp});
  endtask
  task pulse(input logic [7:0] m);
    @(posedge core_clk);
    ev <= m;
    @(posedge core_clk);
    ev <= 8'h00;
  endtask
  task clr;
    @(negedge core_clk);
    logBase = logCnt;
    takeBase = takeCnt;
  endtask
  // waits out one whole logout, then checks count and the code bytes
  task logout(input logic [63:0] code);
    logic [63:0] got;
    repeat (530) @(posedge core_clk);
    chk(takeCnt - takeBase, 1);
    chk(logCnt - logBase, 512);
    for (int k = 0; k < 8; k++)
      got[63 - 8 * k -: 8] = mem[232 + k];
    chk(got, code);
  endtask
  initial
  begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    summarize();
  end
  initial
  begin
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    rd(REG_CTRL, 32'h4);
    rd(REG_STATUS, 32'h100);
    rd(4'hF, 32'h0);
    wr(REG_CTRL, 32'h5);
    clr();
    pulse(8'h10);
    pulse(8'h80);
    repeat (10) @(posedge core_clk);
    chk(takeCnt - takeBase, 0);
    wr(REG_CTRL, 32'h7);
    logout(64'h0081_0000_0000_0000 | VAL);
    rd(REG_CODE_HI, 32'h0081_0F1D);
    rd(REG_CODE_LO, 32'h0003_0000);
    rd(REG_STATUS, 32'h180);
    wr(REG_CTRL, 32'hF);
    rd(REG_STATUS, 32'h100);
    wr(REG_CTRL, 32'h3);
    clr();
    pulse(8'h0C);
    repeat (10) @(posedge core_clk);
    chk(takeCnt - takeBase, 0);
    wr(REG_CTRL, 32'h7);
    logout(64'h1800_0000_0000_0000 | VAL);
    wr(REG_CTRL, 32'hF);
    // partial validity: masks, address, fpr, cr, cpu timer only
    vIn <= 4'hA;
    svIn <= 8'h15;
    clr();
    pulse(8'h40);
    repeat (3) @(posedge core_clk);
    chk(takeCnt - takeBase, 0);
    pulse(8'h11);
    logout(64'h8080_0514_0002_0000);
    rd(REG_VALID, 32'h0000_015A);
    wr(REG_CTRL, 32'hE);
    clr();
    pulse(8'h02);
    repeat (3) @(posedge core_clk);
    chk(checkStop, 1);
    chk(takeCnt - takeBase, 0);
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    @(negedge core_clk);
    chk(checkStop, 0);
    pulse(8'h20);
    @(negedge core_clk);
    chk(checkStop, 1);
    // damage arriving during a logout stops the logout after five bytes
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    wr(REG_CTRL, 32'h7);
    clr();
    pulse(8'h01);
    repeat (5) @(posedge core_clk);
    pulse(8'h02);
    @(negedge core_clk);
    chk(checkStop, 1);
    chk(logCnt - logBase, 5);
    chk(takeCnt - takeBase, 1);
    summarize();
  end
endmodule // tb_top
